// >>> counter_array_control_mode_regs.v
/*
 * Control and mode registers of the programmable counter array, with the
 * 16-bit counter and the module 5 watchdog check.
 * Assumes a single-cycle register port: wr_en/rd address valid with data,
 * module events arrive as one-cycle pulses, module irq enables come from
 * the per-module mode registers outside this block.
 */
`include "counter_array_regs.vh"

module counter_array_control_mode_regs (
	clk,
	rst_b,
	reg_addr,
	reg_wr_en,
	reg_wr_data,
	reg_rd_data,
	module_event,
	module_irq_enable,
	timer0_overflow,
	external_count_input,
	cpu_idle,
	module5_compare_high,
	counter_value,
	counter_tick,
	counter_array_irq,
	watchdog_reset
);
	input  wire        clk;
	input  wire        rst_b;
	input  wire [7:0]  reg_addr;
	input  wire        reg_wr_en;
	input  wire [7:0]  reg_wr_data;
	output reg  [7:0]  reg_rd_data;
	input  wire [5:0]  module_event;
	input  wire [5:0]  module_irq_enable;
	input  wire        timer0_overflow;
	input  wire        external_count_input;
	input  wire        cpu_idle;
	input  wire [7:0]  module5_compare_high;
	output wire [15:0] counter_value;
	output wire        counter_tick;
	output wire        counter_array_irq;
	output reg         watchdog_reset;

	reg  [15:0] count_reg;
	reg         counter_overflow_flag;
	reg         counter_run_bit;
	reg  [5:0]  match_flag_reg;
	reg         idle_suspend_bit;
	reg         watchdog_enable_bit;
	reg         watchdog_lock_bit;
	reg  [2:0]  timebase_select_reg;
	reg         overflow_irq_enable;
	reg  [5:0]  match_flag_next;
	reg         overflow_next;

	wire        ctrl_wr;
	wire        mode_wr;
	wire        suspended;
	wire        run_effective;
	wire        tick;
	wire        wrap;
	wire        low_wrap;
	wire        wdt_match_fire;
	wire        wdt_force_fire;

	// ==================================================
	// decode and counter control
	assign ctrl_wr = reg_wr_en & (reg_addr == `CTRL_ADDR);
	assign mode_wr = reg_wr_en & (reg_addr == `MODE_ADDR);

	assign suspended     = idle_suspend_bit & cpu_idle;
	assign run_effective = (counter_run_bit | watchdog_enable_bit) & ~suspended;

	timebase_select u_timebase (
		.clk                  (clk),
		.rst_b                (rst_b),
		.select               (timebase_select_reg),
		.run                  (run_effective),
		.timer0_overflow      (timer0_overflow),
		.external_count_input (external_count_input),
		.tick                 (tick)
	);

	assign counter_tick  = tick;
	assign counter_value = count_reg;
	assign wrap          = tick & (count_reg == 16'hFFFF);
	assign low_wrap      = tick & (count_reg[7:0] == 8'hFF);

	// ==================================================
	// watchdog trigger conditions
	assign wdt_match_fire = watchdog_enable_bit & low_wrap &
		(module5_compare_high == count_reg[15:8]);
	assign wdt_force_fire = watchdog_enable_bit & ctrl_wr &
		reg_wr_data[`CTRL_WDT_FLAG];

	// the counter itself
	always @(posedge clk) begin
		if (!rst_b)
			count_reg <= 16'h0000;
		else if (tick)
			count_reg <= count_reg + 16'h0001;
	end

	// ==================================================
	// flag next-state: software write loads, hardware event sets on top,
	// so an event in the same cycle as a clear is never lost
	always @* begin
		overflow_next   = counter_overflow_flag;
		match_flag_next = match_flag_reg;
		if (ctrl_wr) begin
			overflow_next   = reg_wr_data[`CTRL_OVF_BIT];
			match_flag_next = reg_wr_data[5:0];
		end
		if (wrap)
			overflow_next = 1'b1;
		match_flag_next = match_flag_next | (module_event & ~suspended_mask(suspended));
	end

	// events are masked while the array is suspended in idle
	function [5:0] suspended_mask;
		input s;
		begin
			suspended_mask = {6{s}};
		end
	endfunction

	// control register
	always @(posedge clk) begin
		if (!rst_b) begin
			counter_overflow_flag <= 1'b0;
			counter_run_bit       <= 1'b0;
			match_flag_reg        <= 6'h00;
		end else begin
			counter_overflow_flag <= overflow_next;
			match_flag_reg        <= match_flag_next;
			if (ctrl_wr)
				counter_run_bit <= reg_wr_data[`CTRL_RUN_BIT];
		end
	end

	// ==================================================
	// mode register; enable locked on by the lock bit
	always @(posedge clk) begin
		if (!rst_b) begin
			idle_suspend_bit    <= 1'b0;
			watchdog_enable_bit <= 1'b1;
			watchdog_lock_bit   <= 1'b0;
			timebase_select_reg <= `TB_DIV12;
			overflow_irq_enable <= 1'b0;
		end else if (mode_wr) begin
			// lock or enable high means the watchdog is on
			if (!watchdog_lock_bit)
				watchdog_enable_bit <= reg_wr_data[`MODE_WATCHDOG_ENABLE_BIT_BIT] |
					reg_wr_data[`MODE_LOCK_BIT];
			// other bits change only while the watchdog is off
			if (!watchdog_enable_bit) begin
				idle_suspend_bit    <= reg_wr_data[`MODE_IDLE_BIT];
				watchdog_lock_bit   <= reg_wr_data[`MODE_LOCK_BIT];
				timebase_select_reg <= reg_wr_data[`MODE_TB_HI:`MODE_TB_LO];
				overflow_irq_enable <= reg_wr_data[`MODE_IRQ_BIT];
			end
		end
	end

	// watchdog reset is a one-cycle registered pulse
	always @(posedge clk) begin
		if (!rst_b)
			watchdog_reset <= 1'b0;
		else
			watchdog_reset <= wdt_match_fire | wdt_force_fire;
	end

	// ==================================================
	// interrupt request; module 5 excluded from irq while it is the watchdog
	assign counter_array_irq = (counter_overflow_flag & overflow_irq_enable) |
		(|(match_flag_reg & module_irq_enable &
		   {~watchdog_enable_bit, 5'h1F}));

	// read mux; bit 4 of the mode register is hard zero
	always @* begin
		if (reg_addr == `CTRL_ADDR)
			reg_rd_data = {counter_overflow_flag, counter_run_bit, match_flag_reg};
		else if (reg_addr == `MODE_ADDR)
			reg_rd_data = {idle_suspend_bit, watchdog_enable_bit, watchdog_lock_bit,
				1'b0, timebase_select_reg, overflow_irq_enable};
		else
			reg_rd_data = 8'h00;
	end
endmodule // counter_array_control_mode_regs

// >>> counter_array_regs.vh
/*
 * Register offsets, field positions, reset values and timebase codes for the
 * counter array control and mode registers.
 * Assumes the including file wants plain `define macros only.
 */
// Function
// - Set overflow flag when the 16-bit counter wraps from 0xFFFF to 0x0000.
// - Hardware never clears overflow or module flags; only software writes do.
// - Request interrupt when overflow flag set and overflow interrupt enable is one.
// - Counter stops when run bit is zero, counts when one.
// - Module event sets its flag; enabled module flag requests the interrupt; code masks the module 5 flag from the interrupt while watchdog enabled.
// - Idle suspend bit one halts the whole array while CPU idles.
// - Watchdog enable runs module 5 as watchdog; resets to one.
// - Once lock is set, watchdog cannot be disabled until system reset.
// - Timebase 000 clock/12, 001 clock/4, 100 clock, 010 timer 0 overflow.
// - Timebase 011 counts falling edges of external input, at most clock/4.
// - Timebase 101 counts external clock divided by 8; codes 11x reserved.
// - While watchdog enabled, writes to other mode bits are rejected.
// - Mode bit 4 always reads zero; writes ignored.
// - Watchdog enabled forces counter running; run bit reads as software wrote it.
// - Watchdog enabled: reset when compare high equals counter high at low overflow.
// - Watchdog enabled: writing one to module 5 flag forces a watchdog reset.
`ifndef COUNTER_ARRAY_REGS_VH
`define COUNTER_ARRAY_REGS_VH

// ==================================================
// register addresses and reset values
`define CTRL_ADDR        8'hD8
`define MODE_ADDR        8'hD9
`define CTRL_RESET       8'h00
`define MODE_RESET       8'h40

// ==================================================
// field positions
`define CTRL_OVF_BIT     7
`define CTRL_RUN_BIT     6
`define CTRL_WDT_FLAG    5
`define MODE_IDLE_BIT    7
`define MODE_WATCHDOG_ENABLE_BIT_BIT    6
`define MODE_LOCK_BIT    5
`define MODE_UNUSED_BIT  4
`define MODE_TB_HI       3
`define MODE_TB_LO       1
`define MODE_IRQ_BIT     0

// ==================================================
// timebase codes and divider counts
`define TB_DIV12         3'h0
`define TB_DIV4          3'h1
`define TB_TIMER0        3'h2
`define TB_EXT_FALL      3'h3
`define TB_SYSCLK        3'h4
`define TB_EXT_DIV8      3'h5
`define DIV12_LAST       4'hB
`define DIV4_LAST        4'h3
`define EXT_DIV8_LAST    3'h7

`endif

// >>> timebase_select.v
/*
 * Timebase pulse generator: produces one-cycle count enables from the
 * selected source.
 * Assumes external input and timer 0 overflow are synchronous to clk.
 */
`include "counter_array_regs.vh"

module timebase_select (
	clk,
	rst_b,
	select,
	run,
	timer0_overflow,
	external_count_input,
	tick
);
	input  wire       clk;
	input  wire       rst_b;
	input  wire [2:0] select;
	input  wire       run;
	input  wire       timer0_overflow;
	input  wire       external_count_input;
	output wire       tick;

	reg  [3:0] div_reg;
	reg        ext_last_reg;
	reg  [2:0] ext_div_reg;
	reg        sel_tick;
	wire       ext_fall;

	// ==================================================
	// prescaler and edge detection
	assign ext_fall = ext_last_reg & ~external_count_input;

	// prescaler free-runs so that a gated counter resumes on the same grid
	always @(posedge clk) begin
		if (!rst_b) begin
			div_reg      <= 4'h0;
			ext_last_reg <= 1'b1;
			ext_div_reg  <= 3'h0;
		end else begin
			ext_last_reg <= external_count_input;
			if (div_reg == `DIV12_LAST)
				div_reg <= 4'h0;
			else
				div_reg <= div_reg + 4'h1;
			if (ext_fall)
				ext_div_reg <= ext_div_reg + 3'h1;
		end
	end

	// source mux; reserved codes give no ticks
	always @* begin
		case (select)
		`TB_DIV12:    sel_tick = (div_reg == `DIV12_LAST);
		`TB_DIV4:     sel_tick = ({2'h0, div_reg[1:0]} == `DIV4_LAST);
		`TB_TIMER0:   sel_tick = timer0_overflow;
		`TB_EXT_FALL: sel_tick = ext_fall;
		`TB_SYSCLK:   sel_tick = 1'b1;
		`TB_EXT_DIV8: sel_tick = ext_fall & (ext_div_reg == `EXT_DIV8_LAST);
		default:      sel_tick = 1'b0;
		endcase
	end

	assign tick = sel_tick & run;
endmodule // timebase_select

// >>> counter_array_asserts.sv
/* concurrent checks on the counter array control and mode register ports.
 * assumes one clk domain and a synchronous active-low rst_b. */
module counter_array_asserts (
	input wire        clk,
	input wire        rst_b,
	input wire [7:0]  reg_addr,
	input wire        reg_wr_en,
	input wire [7:0]  reg_wr_data,
	input wire [7:0]  reg_rd_data,
	input wire [5:0]  module_event,
	input wire [5:0]  module_irq_enable,
	input wire        cpu_idle,
	input wire [15:0] counter_value,
	input wire        counter_tick,
	input wire        counter_array_irq,
	input wire        watchdog_reset
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	// control reads are only trusted when no write lands on that edge
	wire rd_ctl = reg_addr == 8'hD8 && !reg_wr_en;
	wire wr_run = reg_wr_data[6];
	// ========================================
	// register view
	a_reset_mode: assert property ($rose(rst_b) && reg_addr == 8'hD9 |-> reg_rd_data == 8'h40)
		else $error("mode reset value wrong");
	a_mode_bit4: assert property (reg_addr == 8'hD9 |-> !reg_rd_data[4])
		else $error("mode bit 4 reads one");
	a_flags_sticky: assert property (rd_ctl ##1 rd_ctl |-> ($past(reg_rd_data) & ~reg_rd_data & 8'hBF) == 8'h00)
		else $error("flag cleared without a write");
	a_run_stored: assert property (reg_wr_en && reg_addr == 8'hD8 ##1 rd_ctl |-> reg_rd_data[6] == $past(wr_run))
		else $error("run bit not stored");
	// ========================================
	// counter and events
	a_stop_holds: assert property (!counter_tick |=> $stable(counter_value))
		else $error("counter moved without tick");
	a_tick_step: assert property (counter_tick |=> counter_value == $past(counter_value) + 16'h0001)
		else $error("counter step wrong");
	a_ovf_flag: assert property (counter_tick && counter_value == 16'hFFFF && !reg_wr_en ##1 rd_ctl |-> reg_rd_data[7])
		else $error("overflow flag not set");
	a_event_flag: assert property (module_event[0] && !cpu_idle && !reg_wr_en ##1 rd_ctl |-> reg_rd_data[0])
		else $error("module flag not set");
	a_event_irq: assert property (module_event[0] && !cpu_idle && module_irq_enable[0] ##1 module_irq_enable[0] |-> counter_array_irq)
		else $error("module irq missing");
	a_wdt_pulse: assert property (watchdog_reset |=> !watchdog_reset)
		else $error("watchdog reset longer than one cycle");
	c_overflow: cover property (counter_tick && counter_value == 16'hFFFF);
	c_event: cover property (module_event[0] && module_irq_enable[0]);
	c_wdt: cover property (watchdog_reset);
endmodule // counter_array_asserts

bind counter_array_control_mode_regs counter_array_asserts i_chk (.clk(clk), .rst_b(rst_b),
	.reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
	.reg_rd_data(reg_rd_data), .module_event(module_event), .module_irq_enable(module_irq_enable),
	.cpu_idle(cpu_idle), .counter_value(counter_value), .counter_tick(counter_tick),
	.counter_array_irq(counter_array_irq), .watchdog_reset(watchdog_reset));

// >>> counter_array_control_mode_regs_test.sv
/* self-checking bench for the counter array control and mode registers.
 * assumes the single-cycle register port; inputs change at falling edges. */
module counter_array_control_mode_regs_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk, rst_b, reg_wr_en, timer0_overflow, external_count_input, cpu_idle;
	logic        counter_tick, counter_array_irq, watchdog_reset;
	logic [7:0]  reg_addr, reg_wr_data, reg_rd_data, module5_compare_high;
	logic [5:0]  module_event, module_irq_enable;
	logic [15:0] counter_value, c0;
	int          miscompares, n_checks, cyc, wdr_cnt, w0;
	// expected counts per timebase code over 192 clocks
	logic [15:0] tb_exp [8] = '{16'h10, 16'h30, 16'h40, 16'h18, 16'hC0, 16'h3, 16'h0, 16'h0};

	counter_array_control_mode_regs i_dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
		.module_event(module_event), .module_irq_enable(module_irq_enable),
		.timer0_overflow(timer0_overflow), .external_count_input(external_count_input),
		.cpu_idle(cpu_idle), .module5_compare_high(module5_compare_high),
		.counter_value(counter_value), .counter_tick(counter_tick),
		.counter_array_irq(counter_array_irq), .watchdog_reset(watchdog_reset));

	// ========================================
	// clock, sources and pulse counting
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// external edge every 8 clocks keeps under the clk/4 limit
	always @(negedge clk) begin
		cyc++;
		timer0_overflow <= cyc % 3 == 0;
		external_count_input <= cyc[2];
	end
	always @(posedge clk) if (watchdog_reset) wdr_cnt++;

	// ========================================
	// access tasks
	task check(input string name, input logic [15:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// strobe is dropped a full cycle before the next write may raise it
	task wr(input logic [7:0] a, d);
		reg_addr = a;
		reg_wr_data = d;
		reg_wr_en = 1'b1;
		@(negedge clk);
		reg_wr_en = 1'b0;
		@(negedge clk);
	endtask
	task rc(input logic [7:0] a, e);
		reg_addr = a;
		#1 check($sformatf("reg %h", a), reg_rd_data, e);
	endtask
	task counted(input int n, input logic [15:0] e, input string name);
		c0 = counter_value;
		repeat (n) @(negedge clk);
		check(name, counter_value - c0, e);
	endtask
	task results;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ========================================
	// watchdog on the run itself
	initial begin
		repeat (75000) @(posedge clk);
		miscompares++;
		results();
	end

	// ========================================
	// main sequence
	initial begin
		{rst_b, reg_wr_en, reg_wr_data, cpu_idle, module_event, module_irq_enable} = '0;
		reg_addr = 8'hD9;
		module5_compare_high = 8'h80;
		repeat (5) @(negedge clk);
		rst_b = 1'b1;
		rc(8'h10, 8'h00);
		rc(8'hD8, 8'h00);
		rc(8'hD9, 8'h40);
		wr(8'hD9, 8'hCF);
		rc(8'hD9, 8'h40);
		wr(8'hD9, 8'h00);
		rc(8'hD9, 8'h00);
		wr(8'hD9, 8'h19);
		rc(8'hD9, 8'h09);
		wr(8'hD8, 8'h40);
		for (int n = 0; n < 70000 && counter_value !== 16'hFFFF; n++) @(negedge clk);
		check("wrap wait", counter_value, 16'hFFFF);
		@(negedge clk);
		rc(8'hD8, 8'hC0);
		check("irq", counter_array_irq, 1'b1);
		wr(8'hD9, 8'h08);
		check("irq", counter_array_irq, 1'b0);
		wr(8'hD8, 8'h40);
		rc(8'hD8, 8'h40);
		module_irq_enable = 6'h01;
		module_event = 6'h3F;
		@(negedge clk);
		module_event = 6'h00;
		repeat (3) @(negedge clk);
		rc(8'hD8, 8'h7F);
		check("irq", counter_array_irq, 1'b1);
		wr(8'hD8, 8'h40);
		check("irq", counter_array_irq, 1'b0);
		cpu_idle = 1'b1;
		counted(4, 16'h4, "idle run");
		wr(8'hD9, 8'h88);
		counted(4, 16'h0, "idle halt");
		cpu_idle = 1'b0;
		wr(8'hD8, 8'h00);
		counted(4, 16'h0, "stopped");
		wr(8'hD8, 8'h40);
		for (int i = 0; i < 8; i++) begin
			wr(8'hD9, {4'h0, i[2:0], 1'b0});
			counted(192, tb_exp[i], "timebase");
		end
		wr(8'hD8, 8'h00);
		wr(8'hD9, 8'h48);
		counted(8, 16'h8, "forced run");
		rc(8'hD8, 8'h00);
		module5_compare_high = counter_value[15:8];
		w0 = wdr_cnt;
		repeat (300) @(negedge clk);
		check("match reset", wdr_cnt - w0, 1);
		module5_compare_high = counter_value[15:8] + 8'h80;
		w0 = wdr_cnt;
		wr(8'hD8, 8'h20);
		@(negedge clk);
		check("forced reset", wdr_cnt - w0, 1);
		wr(8'hD9, 8'h08);
		wr(8'hD9, 8'h28);
		rc(8'hD9, 8'h68);
		wr(8'hD9, 8'h08);
		rc(8'hD9, 8'h68);
		results();
	end
endmodule // counter_array_control_mode_regs_test
